// File: design/rup_ctrl.sv
// Remote upgrade reconfiguration controller with user watchdog.
//
// Decided for this implementation: the plain strobed port and the register offsets.
module rup_ctrl
   import rup_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire rup_bus_req_t bus_req,
   output logic [BUS_W-1:0] rd_data,
   input wire logic upgrade_shift_clock,
   input wire logic fabric_reconfig_trigger_n,
   input wire logic watchdog_reload_n,
   input wire logic config_reset_n,
   input wire logic config_status_n,
   input wire logic crc_error,
   output logic reconfig_start,
   output logic application_image_flag,
   output logic [PAGE_W-1:0] page_address,
   output logic user_mode,
   output rup_status_t cause_status
);

   typedef struct packed {
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic uclk_prev;
      logic trig_prev;
      logic [CTRL_W-1:0] shift;
      rup_ctrl_t update;
      rup_ctrl_t ctrl;
      rup_status_t status;
      rup_fsm_t fsm;
      logic [4:0] cfg_cnt;
      logic user;
      logic reconfig_start;
      logic [BUS_W-1:0] rd_data;
   } rup_state_t;

   // Synchronisers reset to the idle levels of their pins, so no false event follows reset.
   localparam rup_state_t ST_RST = '{
      sync1: 4'h3, sync2: 4'h3, uclk_prev: 1'b0, trig_prev: 1'b1,
      shift: '0, update: CTRL_RST, ctrl: CTRL_RST, status: STATUS_RST,
      fsm: RUP_CFG, cfg_cnt: CFG_CNT_RST, user: 1'b0, reconfig_start: 1'b0,
      rd_data: 32'h00000000
   };

   rup_state_t st_r;
   rup_state_t st_nxt;
   logic tick;
   logic wd_enable;
   logic wd_expired;
   logic ext_reset_n_s;
   logic cfg_status_n_s;
   logic crc_s;
   logic uclk_s;
   logic trig_rise;
   rup_ctrl_t img;
   rup_status_t cause;

   rup_osc_tick u_tick (
      .sys_clk(sys_clk),
      .rst(rst),
      .tick(tick)
   );

   // The watchdog runs only in an application image in user mode.
   assign wd_enable = st_r.user && st_r.ctrl.application_image_flag && st_r.ctrl.wd_en;

   rup_watchdog u_wd (
      .sys_clk(sys_clk),
      .rst(rst),
      .tick(tick),
      .enable(wd_enable),
      .watchdog_timeout_field(st_r.ctrl.watchdog_timeout_field),
      .watchdog_reload_n(watchdog_reload_n),
      .expired(wd_expired)
   );

   assign ext_reset_n_s = st_r.sync2[0];
   assign cfg_status_n_s = st_r.sync2[1];
   assign crc_s = st_r.sync2[2];
   assign uclk_s = st_r.sync2[3];

   always_comb begin
      st_nxt = st_r;
      cause = STATUS_RST;
      trig_rise = 1'b0;
      st_nxt.reconfig_start = 1'b0;
      st_nxt.rd_data = 32'h00000000;
      st_nxt.sync1 = {upgrade_shift_clock, crc_error, config_status_n, config_reset_n};
      st_nxt.sync2 = st_r.sync1;

      // Software writes land in the shift register while a factory image runs.
      if (bus_req.wr && !st_r.ctrl.application_image_flag) begin
         case (bus_req.addr)
            ADDR_IMG_LO: begin
               st_nxt.shift[BUS_W-1:0] = bus_req.wdata;
            end
            ADDR_IMG_HI: begin
               st_nxt.shift[CTRL_W-1:BUS_W] = bus_req.wdata[CTRL_HI_W-1:0];
            end
            default: begin
            end
         endcase
      end

      // Update operation: rising edge of the upgrade clock commits the shift register.
      st_nxt.uclk_prev = uclk_s;
      if (uclk_s && !st_r.uclk_prev && !st_r.ctrl.application_image_flag) begin
         st_nxt.update = rup_ctrl_t'(st_r.shift);
      end

      img = st_r.ctrl.application_image_flag ? st_r.ctrl : st_r.update;
      if (bus_req.rd) begin
         case (bus_req.addr)
            ADDR_IMG_LO: begin
               st_nxt.rd_data = img[BUS_W-1:0];
            end
            ADDR_IMG_HI: begin
               st_nxt.rd_data = BUS_W'(img[CTRL_W-1:BUS_W]);
            end
            ADDR_STATUS: begin
               st_nxt.rd_data = BUS_W'(st_r.status);
            end
            ADDR_STATE: begin
               st_nxt.rd_data = BUS_W'({wd_expired, st_r.user, st_r.ctrl.application_image_flag});
            end
            default: begin
               st_nxt.rd_data = 32'h00000000;
            end
         endcase
      end

      // Control, status and the sequencer advance on oscillator ticks only.
      if (tick) begin
         trig_rise = fabric_reconfig_trigger_n && !st_r.trig_prev;
         st_nxt.trig_prev = fabric_reconfig_trigger_n;
         case (st_r.fsm)
            RUP_CFG: begin
               st_nxt.user = 1'b0;
               if (!ext_reset_n_s) begin
                  st_nxt.cfg_cnt = CFG_CNT_RST;
               end else if (crc_s && st_r.ctrl.application_image_flag) begin
                  // A corrupt application image falls back to the factory image.
                  st_nxt.ctrl = CTRL_RST;
                  st_nxt.status = '{crc: 1'b1, default: 1'b0};
                  st_nxt.cfg_cnt = CFG_CNT_RST;
                  st_nxt.reconfig_start = 1'b1;
               end else if (st_r.cfg_cnt == CFG_LAST) begin
                  st_nxt.fsm = RUP_RUN;
                  st_nxt.user = 1'b1;
               end else begin
                  st_nxt.cfg_cnt = st_r.cfg_cnt + 5'h01;
               end
            end
            RUP_RUN: begin
               // Priority: external reset, status error, watchdog, fabric trigger.
               if (!ext_reset_n_s) begin
                  cause.ext_reset = 1'b1;
               end else if (!cfg_status_n_s) begin
                  cause.cfg_status = 1'b1;
               end else if (wd_expired) begin
                  cause.watchdog_cause_flag = 1'b1;
               end else if (trig_rise && !st_r.ctrl.application_image_flag) begin
                  cause.fabric = 1'b1;
               end
               if (cause != STATUS_RST) begin
                  st_nxt.status = cause;
                  st_nxt.ctrl = cause.fabric ? st_r.update : CTRL_RST;
                  st_nxt.fsm = RUP_CFG;
                  st_nxt.user = 1'b0;
                  st_nxt.cfg_cnt = CFG_CNT_RST;
                  st_nxt.reconfig_start = 1'b1;
               end
            end
            default: begin
               st_nxt.fsm = RUP_CFG;
               st_nxt.user = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rd_data = st_r.rd_data;
   assign reconfig_start = st_r.reconfig_start;
   assign application_image_flag = st_r.ctrl.application_image_flag;
   assign page_address = st_r.ctrl.page;
   assign user_mode = st_r.user;
   assign cause_status = st_r.status;

   property p_update_locked;
      @(posedge sys_clk) disable iff (rst)
         st_r.ctrl.application_image_flag |=> st_r.update == $past(st_r.update);
   endproperty
   a_update_locked: assert property (p_update_locked) else $error("staged register changed in app image");

   property p_fabric_copy;
      @(posedge sys_clk) disable iff (rst)
         (st_nxt.reconfig_start && st_nxt.status.fabric) |=> st_r.ctrl == $past(st_r.update) && st_r.fsm == RUP_CFG;
   endproperty
   a_fabric_copy: assert property (p_fabric_copy) else $error("trigger did not copy staged register");

   property p_error_clears;
      @(posedge sys_clk) disable iff (rst)
         (st_r.reconfig_start && !st_r.status.fabric) |-> st_r.ctrl == CTRL_RST;
   endproperty
   a_error_clears: assert property (p_error_clears) else $error("error did not clear control");

   property p_one_cause;
      @(posedge sys_clk) disable iff (rst) st_r.reconfig_start |-> $onehot(st_r.status);
   endproperty
   a_one_cause: assert property (p_one_cause) else $error("status not a single cause");

   property p_read_image;
      @(posedge sys_clk) disable iff (rst)
         (bus_req.rd && bus_req.addr == ADDR_IMG_LO)
         |=> rd_data == $past(st_r.ctrl.application_image_flag ? st_r.ctrl[31:0] : st_r.update[31:0]);
   endproperty
   a_read_image: assert property (p_read_image) else $error("image read returned wrong register");

   property p_wd_expiry;
      @(posedge sys_clk) disable iff (rst)
         (tick && st_r.fsm == RUP_RUN && wd_expired && ext_reset_n_s && cfg_status_n_s)
         |=> st_r.status.watchdog_cause_flag && st_r.reconfig_start && !st_r.user;
   endproperty
   a_wd_expiry: assert property (p_wd_expiry) else $error("expiry did not reload factory image");

   property p_wd_off_cfg;
      @(posedge sys_clk) disable iff (rst) (st_r.fsm == RUP_CFG) |-> !wd_enable;
   endproperty
   a_wd_off_cfg: assert property (p_wd_off_cfg) else $error("watchdog on during configuration");

   property p_app_write_refused;
      @(posedge sys_clk) disable iff (rst)
         (bus_req.wr && st_r.ctrl.application_image_flag) |=> st_r.shift == $past(st_r.shift);
   endproperty
   a_app_write_refused: assert property (p_app_write_refused) else $error("write taken in app image");

   property p_rd_data_idle;
      @(posedge sys_clk) disable iff (rst) !bus_req.rd |=> rd_data == 32'h00000000;
   endproperty
   a_rd_data_idle: assert property (p_rd_data_idle) else $error("read data stood beyond one cycle");

   property p_read_ctrl_hi;
      @(posedge sys_clk) disable iff (rst)
         (bus_req.rd && bus_req.addr == ADDR_IMG_HI && st_r.ctrl.application_image_flag)
         |=> rd_data[CTRL_HI_W-1:0] == $past(st_r.ctrl[CTRL_W-1:BUS_W]);
   endproperty
   a_read_ctrl_hi: assert property (p_read_ctrl_hi) else $error("app read missed control register");

   property p_status_steady;
      @(posedge sys_clk) disable iff (rst) !st_r.reconfig_start |-> $stable(st_r.status);
   endproperty
   a_status_steady: assert property (p_status_steady) else $error("status changed without an event");

   property p_user_only_run;
      @(posedge sys_clk) disable iff (rst) st_r.user |-> st_r.fsm == RUP_RUN;
   endproperty
   a_user_only_run: assert property (p_user_only_run) else $error("user mode outside run state");

   property p_wd_off_factory;
      @(posedge sys_clk) disable iff (rst) !st_r.ctrl.application_image_flag |-> !wd_enable;
   endproperty
   a_wd_off_factory: assert property (p_wd_off_factory) else $error("watchdog on in factory image");

   property p_osc_domain;
      @(posedge sys_clk) disable iff (rst) !tick |=> $stable(st_r.ctrl) && $stable(st_r.status);
   endproperty
   a_osc_domain: assert property (p_osc_domain) else $error("control moved without a tick");

   property p_start_single;
      @(posedge sys_clk) disable iff (rst) st_r.reconfig_start |=> !st_r.reconfig_start;
   endproperty
   a_start_single: assert property (p_start_single) else $error("start pulse longer than a cycle");

endmodule // rup_ctrl

// File: design/rup_osc_tick.sv
// Divider that makes the 10 MHz oscillator rate as an enable pulse.
module rup_osc_tick
   import rup_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   output logic tick
);

   typedef struct packed {
      logic [4:0] acc;
      logic tick;
   } rup_div_t;

   localparam rup_div_t DIV_RST = '{acc: OSC_ACC_RST, tick: 1'b0};

   rup_div_t st_r;
   rup_div_t st_nxt;
   logic [5:0] sum;

   always_comb begin
      st_nxt = st_r;
      sum = {1'b0, st_r.acc} + OSC_ACC_STEP;
      st_nxt.tick = 1'b0;
      if (sum >= OSC_ACC_MOD) begin
         st_nxt.acc = 5'(sum - OSC_ACC_MOD);
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.acc = sum[4:0];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_r <= DIV_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick = st_r.tick;

   // At 10 of 25 the tick never comes twice in a row.
   property p_tick_spaced;
      @(posedge sys_clk) disable iff (rst) st_r.tick |=> !st_r.tick;
   endproperty
   a_tick_spaced: assert property (p_tick_spaced) else $error("oscillator tick repeated");

endmodule // rup_osc_tick

// File: design/rup_pkg.sv
// Package with constants, types and helpers of the remote upgrade controller.
package rup_pkg;

   localparam int CLK_HZ = 25_000_000;
   localparam int OSC_HZ = 10_000_000;
   localparam int OSC_GRAIN_HZ = 1_000_000;
   // The oscillator tick comes from a fractional accumulator: STEP of every MOD clocks.
   localparam logic [5:0] OSC_ACC_STEP = 6'(OSC_HZ / OSC_GRAIN_HZ);
   localparam logic [5:0] OSC_ACC_MOD = 6'(CLK_HZ / OSC_GRAIN_HZ);
   localparam logic [4:0] OSC_ACC_RST = 5'h00;

   localparam int WD_W = 29;
   localparam int WD_FIELD_W = 12;
   localparam int WD_LOW_W = 17;
   localparam int PAGE_W = 24;
   localparam int CTRL_W = 38;
   localparam int BUS_W = 32;
   localparam int CTRL_HI_W = CTRL_W - BUS_W;
   localparam int STATUS_W = 5;

   // Length of the modelled configuration cycle in oscillator ticks.
   localparam int CFG_TICKS = 16;
   localparam logic [4:0] CFG_LAST = 5'(CFG_TICKS - 1);
   localparam logic [4:0] CFG_CNT_RST = 5'h00;

   localparam logic [7:0] ADDR_IMG_LO = 8'h00;
   localparam logic [7:0] ADDR_IMG_HI = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_STATE = 8'h0c;

   typedef enum logic {RUP_CFG, RUP_RUN} rup_fsm_t;

   typedef struct packed {
      logic [WD_FIELD_W-1:0] watchdog_timeout_field;
      logic wd_en;
      logic [PAGE_W-1:0] page;
      logic application_image_flag;
   } rup_ctrl_t;

   typedef struct packed {
      logic watchdog_cause_flag;
      logic ext_reset;
      logic fabric;
      logic cfg_status;
      logic crc;
   } rup_status_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [BUS_W-1:0] wdata;
      logic wr;
      logic rd;
   } rup_bus_req_t;

   localparam rup_ctrl_t CTRL_RST = '0;
   localparam rup_status_t STATUS_RST = '0;
   localparam logic [WD_W-1:0] WD_CNT_RST = 29'h0000000;

   function automatic logic [WD_W-1:0] rup_wd_start(input logic [WD_FIELD_W-1:0] field);
      return {field, {WD_LOW_W{1'b0}}};
   endfunction

endpackage

// File: design/rup_watchdog.sv
// 29-bit down-counting user watchdog.
module rup_watchdog
   import rup_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic enable,
   input wire logic [WD_FIELD_W-1:0] watchdog_timeout_field,
   input wire logic watchdog_reload_n,
   output logic expired
);

   typedef struct packed {
      logic [WD_W-1:0] count;
      logic expired;
   } rup_wd_t;

   localparam rup_wd_t WD_RST = '{count: WD_CNT_RST, expired: 1'b0};

   rup_wd_t st_r;
   rup_wd_t st_nxt;
   logic [WD_W-1:0] start;

   always_comb begin
      st_nxt = st_r;
      start = rup_wd_start(watchdog_timeout_field);
      if (!enable) begin
         // Held at the start value while disabled.
         st_nxt.count = start;
         st_nxt.expired = 1'b0;
      end else if (!watchdog_reload_n) begin
         st_nxt.count = start;
      end else if (tick && !st_r.expired) begin
         if (st_r.count == WD_CNT_RST) begin
            st_nxt.expired = 1'b1;
         end else begin
            st_nxt.count = st_r.count - 29'h0000001;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_r <= WD_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign expired = st_r.expired;

   property p_wd_dec;
      @(posedge sys_clk) disable iff (rst)
         (enable && watchdog_reload_n && tick && !st_r.expired && st_r.count != 0)
         |=> st_r.count == $past(st_r.count) - 29'h0000001;
   endproperty
   a_wd_dec: assert property (p_wd_dec) else $error("watchdog did not step down once");

   property p_wd_hold;
      @(posedge sys_clk) disable iff (rst)
         (!enable || !watchdog_reload_n) |=> st_r.count == {$past(watchdog_timeout_field), 17'h00000}
         && ($past(enable) || !st_r.expired);
   endproperty
   a_wd_hold: assert property (p_wd_hold) else $error("watchdog not at start value");

   property p_wd_no_tick;
      @(posedge sys_clk) disable iff (rst) (enable && watchdog_reload_n && !tick) |=> $stable(st_r.count);
   endproperty
   a_wd_no_tick: assert property (p_wd_no_tick) else $error("watchdog moved without a tick");

endmodule // rup_watchdog

// File: test/rup_user_model.sv
// Behavioural model of the fabric user logic that stages, triggers and reloads the controller.
module rup_user_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [1:0] cmd,
   input wire logic kick_en,
   output logic upgrade_shift_clock,
   output logic fabric_reconfig_trigger_n,
   output logic watchdog_reload_n
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [3:0] stage_cnt_r;
   logic [3:0] trig_cnt_r;
   logic [5:0] kick_cnt_r;

   // Command 1 raises the update clock for six cycles, long enough for the two-stage synchroniser.
   // Command 2 holds the trigger low for eight cycles so that an oscillator tick sees it low before the rise.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         stage_cnt_r <= 4'h0;
         trig_cnt_r <= 4'h0;
         kick_cnt_r <= 6'h00;
      end else begin
         if (cmd == 2'h1) begin
            stage_cnt_r <= 4'h6;
         end else if (stage_cnt_r != 4'h0) begin
            stage_cnt_r <= stage_cnt_r - 4'h1;
         end
         if (cmd == 2'h2) begin
            trig_cnt_r <= 4'h8;
         end else if (trig_cnt_r != 4'h0) begin
            trig_cnt_r <= trig_cnt_r - 4'h1;
         end
         kick_cnt_r <= kick_cnt_r + 6'h01;
      end
   end

   assign upgrade_shift_clock = (stage_cnt_r != 4'h0);
   assign fabric_reconfig_trigger_n = (trig_cnt_r == 4'h0);
   // A one-cycle reload every 64 cycles keeps the count far from expiry when the timeout field is nonzero.
   assign watchdog_reload_n = !(kick_en && kick_cnt_r == 6'h00);
endmodule // rup_user_model

// File: test/test_rup_ctrl.sv
// Self-checking testbench of the remote upgrade controller.
module test_rup_ctrl
   import rup_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic sys_clk = 1'b0;
   logic rst;
   rup_bus_req_t bus_req;
   logic [BUS_W-1:0] rd_data;
   logic upgrade_shift_clock;
   logic fabric_reconfig_trigger_n;
   logic watchdog_reload_n;
   logic config_reset_n;
   logic config_status_n;
   logic crc_error;
   logic reconfig_start;
   logic application_image_flag;
   logic [PAGE_W-1:0] page_address;
   logic user_mode;
   rup_status_t cause_status;
   logic [1:0] cmd;
   logic kick_en;
   int bad_count = 0;
   int checks_done = 0;
   rup_ctrl_t stg = '{12'h001, 1'b1, 24'h5a3c71, 1'b1};
   logic [CTRL_W-1:0] img;
   rup_ctrl_t stg_wd = '{12'h000, 1'b1, 24'h00c0de, 1'b1};
   logic [CTRL_W-1:0] img_wd;

   assign img = stg;
   assign img_wd = stg_wd;

   always #20 sys_clk = ~sys_clk;

   rup_ctrl DUT (
      .sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
      .upgrade_shift_clock(upgrade_shift_clock), .fabric_reconfig_trigger_n(fabric_reconfig_trigger_n),
      .watchdog_reload_n(watchdog_reload_n), .config_reset_n(config_reset_n),
      .config_status_n(config_status_n), .crc_error(crc_error), .reconfig_start(reconfig_start),
      .application_image_flag(application_image_flag), .page_address(page_address),
      .user_mode(user_mode), .cause_status(cause_status)
   );

   rup_user_model user (
      .sys_clk(sys_clk), .rst(rst), .cmd(cmd), .kick_en(kick_en),
      .upgrade_shift_clock(upgrade_shift_clock), .fabric_reconfig_trigger_n(fabric_reconfig_trigger_n),
      .watchdog_reload_n(watchdog_reload_n)
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
         bad_count++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      bus_req.addr <= a;
      bus_req.wdata <= d;
      bus_req.wr <= 1'b1;
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe and are zero in the next one.
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1 chk(rd_data, exp);
      @(posedge sys_clk);
      #1 chk(rd_data, 32'h0);
   endtask

   task automatic do_cmd(input logic [1:0] c);
      @(posedge sys_clk);
      cmd <= c;
      @(posedge sys_clk);
      cmd <= 2'h0;
   endtask

   // Waits a bounded number of cycles for the start pulse (sel 0) or user mode (sel 1).
   task automatic wait_for(input logic sel, input int lim, input logic want);
      logic hit;
      hit = 1'b0;
      for (int n = 0; n < lim && !hit; n++) begin
         @(posedge sys_clk);
         #1 hit = ((sel ? user_mode : reconfig_start) === 1'b1);
      end
      chk(32'(hit), 32'(want));
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #(40 * 20000);
      bad_count++;
      close_out();
   end

   // A zero timeout field expires on the first tick, which brings expiry within the run length.
   initial begin
      rst = 1'b1;
      bus_req = '0;
      cmd = 2'h0;
      kick_en = 1'b0;
      config_reset_n = 1'b1;
      config_status_n = 1'b1;
      crc_error = 1'b0;
      repeat (16) @(posedge sys_clk);
      chk(32'(cause_status), 32'h0);
      chk(32'(user_mode), 32'h0);
      rst <= 1'b0;
      wait_for(1'b1, 300, 1'b1);
      chk(32'(application_image_flag), 32'h0);
      $display("test power_up done");

      wr(ADDR_IMG_LO, img[31:0]);
      wr(ADDR_IMG_HI, 32'(img[CTRL_W-1:BUS_W]));
      do_cmd(2'h1);
      repeat (12) @(posedge sys_clk);
      rd(ADDR_IMG_LO, img[31:0]);
      rd(ADDR_IMG_HI, 32'(img[CTRL_W-1:BUS_W]));
      rd(ADDR_STATUS, 32'h0);
      rd(8'h40, 32'h0);
      chk(32'(page_address), 32'h0);
      $display("test staging done");

      do_cmd(2'h2);
      kick_en <= 1'b1;
      wait_for(1'b0, 40, 1'b1);
      chk(32'(page_address), 32'h5a3c71);
      chk(32'(application_image_flag), 32'h1);
      chk(32'(cause_status), 32'h04);
      wait_for(1'b1, 300, 1'b1);
      $display("test trigger done");

      rd(ADDR_IMG_LO, img[31:0]);
      rd(ADDR_IMG_HI, 32'(img[CTRL_W-1:BUS_W]));
      wr(ADDR_IMG_LO, 32'h0);
      do_cmd(2'h1);
      repeat (12) @(posedge sys_clk);
      rd(ADDR_IMG_LO, img[31:0]);
      rd(ADDR_STATE, 32'h3);
      do_cmd(2'h2);
      wait_for(1'b0, 40, 1'b0);
      $display("test application done");

      for (int i = 0; i < 2; i++) begin
         @(posedge sys_clk);
         if (i == 0) begin
            config_status_n <= 1'b0;
         end else begin
            config_reset_n <= 1'b0;
         end
         wait_for(1'b0, 40, 1'b1);
         chk(32'(cause_status), (i == 0) ? 32'h02 : 32'h08);
         chk(32'(page_address), 32'h0);
         chk(32'(application_image_flag), 32'h0);
         @(posedge sys_clk);
         config_status_n <= 1'b1;
         config_reset_n <= 1'b1;
         wait_for(1'b1, 300, 1'b1);
         rd(ADDR_IMG_LO, img[31:0]);
      end
      $display("test pin_errors done");

      do_cmd(2'h2);
      wait_for(1'b0, 40, 1'b1);
      chk(32'(cause_status), 32'h04);
      @(posedge sys_clk);
      crc_error <= 1'b1;
      repeat (6) @(posedge sys_clk);
      crc_error <= 1'b0;
      wait_for(1'b1, 300, 1'b1);
      chk(32'(cause_status), 32'h01);
      chk(32'(application_image_flag), 32'h0);
      chk(32'(page_address), 32'h0);
      $display("test crc_error done");

      wr(ADDR_IMG_LO, img_wd[31:0]);
      wr(ADDR_IMG_HI, 32'(img_wd[CTRL_W-1:BUS_W]));
      do_cmd(2'h1);
      repeat (12) @(posedge sys_clk);
      rd(ADDR_IMG_LO, img_wd[31:0]);
      do_cmd(2'h2);
      wait_for(1'b0, 40, 1'b1);
      chk(32'(page_address), 32'h00c0de);
      wait_for(1'b1, 300, 1'b1);
      wait_for(1'b0, 40, 1'b1);
      chk(32'(cause_status), 32'h10);
      chk(32'(application_image_flag), 32'h0);
      chk(32'(page_address), 32'h0);
      $display("test watchdog done");
      close_out();
   end
endmodule // test_rup_ctrl
